/* File: verilog/ccb_pkg.sv */
/*
 * Shared constants and types for the processor clock, reset and bus support block.
 * Assumes clk is the base pixel clock, so one clk period is one base period (70 ns
 * nominal). All pin inputs pass the two-flop synchroniser before use.
 */
// Behaviour
// - Ring counter divides base clock by 5/6/7
// - Phase one low while stages two, four set
// - Wide option: phase two low if B or C zero
// - Fast wide rate: phase two low 210 nsec
// - Narrow option: phase two low if B zero
// - Phase two gated off during phase one so phases never overlap
// - Low widths 140/280 slow, 70/210 fast
// - Bus clock follows phase two by 70 nsec
// - Ready, reset, hold registered on bus clock
// - Ready input combines two pulled-up ready lines
// - Power-on clear holds processor reset active
// - First edge after clear forces ready low
// - Forced not-ready ends on following edge
// - Hold register ignores power-on clear, samples always
// - Phantom low for first four fetches
// - Read strobe follows data-in unless DMA overrides
// - Control drivers float when control disable low
// - Status latched mid sync by sync and phase two
// - Status drivers off when status disable asserted
// - Data-out drivers on unless internal read, disable
// - Address drivers on unless address disable asserted
// - Input multiplexer drives only during data-in
// - Select shared, keyboard, parallel, internal buses
// - Memory selects internal; display page selects shared
package ccb_pkg;

    // Base period and documented widths
    localparam int BASE_CLK_NS     = 70;
    localparam int PH1_SLOW_NS     = 140;
    localparam int PH1_FAST_NS     = 70;
    localparam int PH2_SLOW_NS     = 280;
    localparam int PH2_FAST_NS     = 210;
    localparam int BUS_CLK_LAG_NS  = 70;
    localparam int PH1_SLOW_CYC    = (PH1_SLOW_NS + BASE_CLK_NS - 1) / BASE_CLK_NS;
    localparam int PH1_FAST_CYC    = (PH1_FAST_NS + BASE_CLK_NS - 1) / BASE_CLK_NS;
    localparam int PH2_SLOW_CYC    = (PH2_SLOW_NS + BASE_CLK_NS - 1) / BASE_CLK_NS;
    localparam int PH2_FAST_CYC    = (PH2_FAST_NS + BASE_CLK_NS - 1) / BASE_CLK_NS;
    localparam int BUS_CLK_LAG_CYC = (BUS_CLK_LAG_NS + BASE_CLK_NS - 1) / BASE_CLK_NS;

    // Divisor selection codes
    localparam logic [1:0] DIV_SEVEN = 2'h0;
    localparam logic [1:0] DIV_SIX   = 2'h1;
    localparam logic [1:0] DIV_FIVE  = 2'h2;

    // Multiplexer select codes, {input_select_a, input_select_b}
    localparam logic [1:0] SEL_INTERNAL = 2'h0;
    localparam logic [1:0] SEL_KEYBOARD = 2'h1;
    localparam logic [1:0] SEL_PARALLEL = 2'h2;
    localparam logic [1:0] SEL_SHARED   = 2'h3;

    // Reset values
    localparam logic [3:0] RING_RST    = 4'h0;
    localparam logic [3:0] PHANTOM_RST = 4'h0;
    localparam logic [7:0] BYTE_RST    = 8'h00;
    localparam int         PHANTOM_FETCHES = 4;

    // All pin inputs, gathered for synchronising
    typedef struct packed {
        logic [7:0] dio;
        logic [7:0] kdb;
        logic [7:0] pid;
        logic [7:0] intb;
        logic [7:0] cpu_data;
        logic [1:0] div_sel;
        logic       wide_phase;
        logic       prdy;
        logic       xrdy;
        logic       preset_n;
        logic       phold_n;
        logic       power_on_clear_n;
        logic       digi;
        logic       cc_dsb_n;
        logic       stat_dsb_n;
        logic       do_dsb_n;
        logic       add_dsb_n;
        logic       keyboard_port_read;
        logic       parallel_port_read;
        logic       internal_port_sel;
        logic       mem_sel;
        logic       display_page_hit;
        logic       dbin;
        logic       sync;
        logic       inte;
        logic       hlda;
        logic       wr_n;
        logic       cpu_wait;
    } ccb_pins_t;

    // Idle pin levels: pulled-up lines high, power-on clear active
    localparam ccb_pins_t PINS_RST = '{prdy: 1'b1, xrdy: 1'b1, preset_n: 1'b1,
                                       phold_n: 1'b1, cc_dsb_n: 1'b1, stat_dsb_n: 1'b1,
                                       do_dsb_n: 1'b1, add_dsb_n: 1'b1, wr_n: 1'b1,
                                       default: '0};

endpackage

/* File: verilog/ccb_pins_if.sv */
/*
 * Carrier for raw and synchronised pin inputs between the top and its synchroniser.
 * Assumes a single clock shared by both ends.
 */
`timescale 1ns/1ps
interface ccb_pins_if;
    import ccb_pkg::*;
    ccb_pins_t raw;
    ccb_pins_t sync;
    modport syncer (input raw, output sync);
    modport user (output raw, input sync);
endinterface

/* File: verilog/ccb_sync.sv */
/*
 * Two-flop synchroniser for every pin input of the support block.
 * Assumes the raw inputs are asynchronous to clk; only the second stage is read.
 */
`timescale 1ns/1ps
module ccb_sync
    import ccb_pkg::*;
(
    input  wire logic    clk,
    input  wire logic    nrst,
    ccb_pins_if.syncer   pins
);

    typedef struct packed {
        ccb_pins_t s1;
        ccb_pins_t s2;
    } ccb_sync_t;

    ccb_sync_t st;
    ccb_sync_t next_st;

    // Shift raw pins through two stages
    always_comb begin
        next_st    = st;
        next_st.s1 = pins.raw;
        next_st.s2 = st.s1;
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '{s1: PINS_RST, s2: PINS_RST};
        end else begin
            st <= next_st;
        end
    end

    assign pins.sync = st.s2;

endmodule

/* File: verilog/ccb_support.sv */
/*
 * Clock, reset and bus support logic around an 8-bit processor: phase clocks, bus
 * clock, ready/reset/hold registers, phantom start-up, status latch, driver enables
 * and the four-way input data multiplexer.
 * Assumes clk is the base pixel clock and that all inputs are asynchronous pins.
 */
`timescale 1ns/1ps
module ccb_support
    import ccb_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [1:0] div_sel,
    input  wire logic       wide_phase,
    input  wire logic       power_on_clear_n,
    input  wire logic       prdy,
    input  wire logic       xrdy,
    input  wire logic       preset_n,
    input  wire logic       phold_n,
    input  wire logic       digi,
    input  wire logic       cc_dsb_n,
    input  wire logic       stat_dsb_n,
    input  wire logic       do_dsb_n,
    input  wire logic       add_dsb_n,
    input  wire logic       keyboard_port_read,
    input  wire logic       parallel_port_read,
    input  wire logic       internal_port_sel,
    input  wire logic       mem_sel,
    input  wire logic       display_page_hit,
    input  wire logic       cpu_dbin,
    input  wire logic       cpu_sync,
    input  wire logic       cpu_inte,
    input  wire logic       cpu_hlda,
    input  wire logic       cpu_wr_n,
    input  wire logic       cpu_wait,
    input  wire logic [7:0] cpu_data_in,
    input  wire logic [7:0] kdb,
    input  wire logic [7:0] pid,
    input  wire logic [7:0] intb,
    input  wire logic [7:0] dio_in,
    output logic            phase1_n,
    output logic            phase2_n,
    output logic            bus_clock,
    output logic            cpu_reset,
    output logic            cpu_ready,
    output logic            cpu_hold,
    output logic            phantom_n,
    output logic            bus_sync,
    output logic            bus_inte,
    output logic            bus_hlda,
    output logic            bus_wr_n,
    output logic            bus_wait,
    output logic            bus_pdbin,
    output logic            ctl_oe,
    output logic [7:0]      status,
    output logic            status_oe,
    output logic            addr_oe,
    output logic [7:0]      dio_out,
    output logic            dio_oe,
    output logic [7:0]      cpu_data_out,
    output logic            cpu_data_oe,
    output logic            input_select_a,
    output logic            input_select_b,
    output logic            data_out_inhibit
);

    // Whole module state
    typedef struct packed {
        logic [3:0] ring;
        logic [1:0] div;
        logic       wide;
        logic       phase1_n;
        logic       phase2_n;
        logic       bus_clock;
        logic       reset_q;
        logic       ready_q;
        logic       hold_q;
        logic [3:0] phantom_sr;
        logic       dbin_d;
        logic       strobe_d;
        logic [7:0] status;
        logic       bus_sync;
        logic       bus_inte;
        logic       bus_hlda;
        logic       bus_wr_n;
        logic       bus_wait;
        logic       bus_pdbin;
        logic       ctl_oe;
        logic       status_oe;
        logic       addr_oe;
        logic [7:0] dio_out;
        logic       dio_oe;
        logic [7:0] cpu_d;
        logic       cpu_d_oe;
        logic [1:0] sel;
        logic       inhibit;
    } ccb_state_t;

    ccb_state_t st;
    ccb_state_t next_st;
    ccb_pins_t  p;
    logic       bus_rise;
    logic       dbin_fall;
    logic       strobe;
    logic [1:0] next_sel;

    ccb_pins_if pif ();

    // Gather pins for the synchroniser
    always_comb begin
        pif.raw = '{dio: dio_in, kdb: kdb, pid: pid, intb: intb, cpu_data: cpu_data_in,
                    div_sel: div_sel, wide_phase: wide_phase, prdy: prdy, xrdy: xrdy,
                    preset_n: preset_n, phold_n: phold_n,
                    power_on_clear_n: power_on_clear_n, digi: digi, cc_dsb_n: cc_dsb_n,
                    stat_dsb_n: stat_dsb_n, do_dsb_n: do_dsb_n, add_dsb_n: add_dsb_n,
                    keyboard_port_read: keyboard_port_read,
                    parallel_port_read: parallel_port_read,
                    internal_port_sel: internal_port_sel, mem_sel: mem_sel,
                    display_page_hit: display_page_hit, dbin: cpu_dbin, sync: cpu_sync,
                    inte: cpu_inte, hlda: cpu_hlda, wr_n: cpu_wr_n, cpu_wait: cpu_wait};
    end

    ccb_sync u_sync (
        .clk  (clk),
        .nrst (nrst),
        .pins (pif.syncer)
    );

    assign p = pif.sync;

    // Ring feedback: inverted tail through a selectable NAND
    function automatic logic ring_feedback(input logic [3:0] r, input logic [1:0] d);
        logic fb;
        fb = 1'b0;
        unique case (d)
            DIV_SIX:  fb = ~r[1];          // Third stage only
            DIV_FIVE: fb = ~(r[2] & r[1]); // Second and third stages
            default:  fb = ~(r[1] & r[0]); // Third and fourth stages
        endcase
        return fb;
    endfunction

    // Phase two gate output, low while its pulse is active
    function automatic logic phase2_gate(input logic [3:0] r, input logic w);
        return w ? ~(~r[2] | ~r[1]) : r[2];
    endfunction

    // Input select from the port and page decodes, {a, b}
    function automatic logic [1:0] select_decode(input ccb_pins_t q);
        logic internal;
        internal = q.internal_port_sel | (q.mem_sel & ~q.display_page_hit);
        return {~(q.keyboard_port_read | internal), ~(q.parallel_port_read | internal)};
    endfunction

    // Byte chosen by the input multiplexer
    function automatic logic [7:0] mux_byte(input logic [1:0] s, input ccb_pins_t q);
        logic [7:0] b;
        b = q.dio;
        unique case (s)
            SEL_KEYBOARD: b = q.kdb;
            SEL_PARALLEL: b = q.pid;
            SEL_INTERNAL: b = q.intb;
            SEL_SHARED:   b = q.dio;
        endcase
        return b;
    endfunction

    // Next-state logic
    always_comb begin
        next_st = st;
        // Strap inputs taken only while power-on clear holds the device in reset
        if (!p.power_on_clear_n) begin
            next_st.div  = p.div_sel;
            next_st.wide = p.wide_phase;
        end
        // Ring shifts right each base clock with the gated inverted tail
        next_st.ring = {ring_feedback(st.ring, st.div), st.ring[3:1]};
        // Phase one low while second and fourth stages hold one
        next_st.phase1_n = ~(st.ring[2] & st.ring[0]);
        // Phase two low window by option; guard keeps it off during phase one
        next_st.phase2_n = phase2_gate(st.ring, st.wide)
                           | ~next_st.phase1_n;
        // Bus clock is phase two's pulse delayed by one base period
        next_st.bus_clock = ~st.phase2_n;
        bus_rise = next_st.bus_clock & ~st.bus_clock;

        // Ready, reset and hold registers on bus clock rising edges
        if (bus_rise) begin
            next_st.reset_q = ~p.preset_n;
            // Ready low on the edge that releases reset, back on the next
            next_st.ready_q = p.prdy & p.xrdy & ~st.reset_q;
            next_st.hold_q  = ~p.phold_n;
        end
        // Power-on clear forces reset regardless of the bus clock
        if (!p.power_on_clear_n) begin
            next_st.reset_q = 1'b1;
            next_st.ready_q = 1'b0;
        end

        // Phantom shift register steps at the end of each data-in strobe
        next_st.dbin_d = p.dbin;
        dbin_fall = st.dbin_d & ~p.dbin;
        if (!p.power_on_clear_n) begin
            next_st.phantom_sr = PHANTOM_RST;
        end else if (dbin_fall) begin
            next_st.phantom_sr = {st.phantom_sr[2:0], 1'b1};
        end

        // Status latch on the rise of sync gated with phase two
        strobe = p.sync & ~st.phase2_n;
        next_st.strobe_d = strobe;
        if (strobe && !st.strobe_d) begin
            next_st.status = p.cpu_data;
        end
        next_st.status_oe = p.stat_dsb_n;

        // Control signals to the bus and their shared enable
        next_st.bus_sync  = p.sync;
        next_st.bus_inte  = p.inte;
        next_st.bus_hlda  = p.hlda;
        next_st.bus_wr_n  = p.wr_n;
        next_st.bus_wait  = p.cpu_wait;
        next_st.bus_pdbin = p.dbin | p.digi;
        next_st.ctl_oe    = p.cc_dsb_n;
        next_st.addr_oe   = p.add_dsb_n;

        // Input multiplexer select and data
        next_sel = select_decode(p);
        next_st.sel      = next_sel;
        next_st.cpu_d    = mux_byte(next_sel, p);
        next_st.cpu_d_oe = p.dbin;

        // Data-out drivers off while reading an internal source or when disabled
        next_st.inhibit = p.dbin & (next_sel != SEL_SHARED);
        next_st.dio_oe  = ~next_st.inhibit & p.do_dsb_n;
        next_st.dio_out = p.cpu_data;
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '{ring: RING_RST, div: DIV_SEVEN, wide: 1'b1, phase1_n: 1'b1,
                    phase2_n: 1'b1, reset_q: 1'b1, phantom_sr: PHANTOM_RST,
                    status: BYTE_RST, bus_wr_n: 1'b1, ctl_oe: 1'b1, status_oe: 1'b1,
                    addr_oe: 1'b1, dio_out: BYTE_RST, dio_oe: 1'b1, cpu_d: BYTE_RST,
                    sel: SEL_SHARED, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign phase1_n         = st.phase1_n;
    assign phase2_n         = st.phase2_n;
    assign bus_clock        = st.bus_clock;
    assign cpu_reset        = st.reset_q;
    assign cpu_ready        = st.ready_q;
    assign cpu_hold         = st.hold_q;
    assign phantom_n        = st.phantom_sr[3];
    assign bus_sync         = st.bus_sync;
    assign bus_inte         = st.bus_inte;
    assign bus_hlda         = st.bus_hlda;
    assign bus_wr_n         = st.bus_wr_n;
    assign bus_wait         = st.bus_wait;
    assign bus_pdbin        = st.bus_pdbin;
    assign ctl_oe           = st.ctl_oe;
    assign status           = st.status;
    assign status_oe        = st.status_oe;
    assign addr_oe          = st.addr_oe;
    assign dio_out          = st.dio_out;
    assign dio_oe           = st.dio_oe;
    assign cpu_data_out     = st.cpu_d;
    assign cpu_data_oe      = st.cpu_d_oe;
    assign input_select_a   = st.sel[1];
    assign input_select_b   = st.sel[0];
    assign data_out_inhibit = st.inhibit;

    // Checks on the generated waveforms and bus controls
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // Phase pulses never overlap
    phase_overlap_a: assert property (!(!phase1_n && !phase2_n))
        else $error("phase one and phase two active together");

    // Slow rate phase one is two base periods
    ph1_slow_a: assert property (p.power_on_clear_n && st.div == DIV_SEVEN
                                 && $fell(phase1_n) |-> !phase1_n[*2] ##1 phase1_n)
        else $error("slow phase one width wrong");

    // Fast rates phase one is one base period
    ph1_fast_a: assert property (p.power_on_clear_n && st.div != DIV_SEVEN
                                 && $fell(phase1_n) |-> ##1 phase1_n)
        else $error("fast phase one width wrong");

    // Slow wide phase two is four base periods
    ph2_slow_a: assert property (p.power_on_clear_n && st.div == DIV_SEVEN && st.wide
                                 && $fell(phase2_n) |-> !phase2_n[*4] ##1 phase2_n)
        else $error("slow phase two width wrong");

    // Fast wide phase two is three base periods
    ph2_fast_a: assert property (p.power_on_clear_n && st.div == DIV_FIVE && st.wide
                                 && $fell(phase2_n) |-> !phase2_n[*3] ##1 phase2_n)
        else $error("fast phase two width wrong");

    // Narrow middle rate phase two is three base periods
    ph2_mid_a: assert property (p.power_on_clear_n && st.div == DIV_SIX && !st.wide
                                && $fell(phase2_n) |-> !phase2_n[*3] ##1 phase2_n)
        else $error("middle phase two width wrong");

    // Bus clock rises one base period after phase two goes active
    bus_clk_lag_a: assert property ($fell(phase2_n) |-> ##1 $rose(bus_clock))
        else $error("bus clock does not follow phase two");

    // Power-on clear keeps the processor in reset
    poc_reset_a: assert property (!p.power_on_clear_n |-> ##1 cpu_reset && !cpu_ready)
        else $error("reset not held during power-on clear");

    // Ready stays low on the cycle reset releases
    ready_force_a: assert property ($fell(cpu_reset) |-> !cpu_ready)
        else $error("ready not forced low at reset release");

    // Power-on clear holds phantom low and empties its shift register
    phantom_hold_a: assert property (!p.power_on_clear_n |-> ##1 !phantom_n
                                     && st.phantom_sr == PHANTOM_RST)
        else $error("phantom not cleared by power-on clear");

    // Data-out drivers off whenever a non-shared source is read
    data_out_off_a: assert property (cpu_data_oe && st.sel != SEL_SHARED |-> !dio_oe)
        else $error("data out driven during internal read");

    // A lone keyboard port read picks the keyboard bus one cycle later
    mux_select_a: assert property ($past(p.keyboard_port_read
                                   && !p.parallel_port_read && !p.internal_port_sel
                                   && !p.mem_sel) |-> st.sel == SEL_KEYBOARD)
        else $error("multiplexer select wrong");

    // Read strobe high one cycle after a DMA override
    pdbin_follow_a: assert property ($past(p.digi) |-> bus_pdbin)
        else $error("read strobe not overridden by DMA");

    phantom_release_c: cover property ($rose(phantom_n));
    ready_release_c:   cover property ($fell(cpu_reset) ##[1:40] $rose(cpu_ready));
    keyboard_read_c:   cover property (cpu_data_oe && st.sel == SEL_KEYBOARD);
    status_latch_c:    cover property (strobe && !st.strobe_d);

endmodule

/* File: dv/ccb_cpu_model.sv */
/*
 * Behavioural processor model: drives sync, data-in strobe and data lines.
 * Assumes the bench calls fetch from its own process; changes land on falling edges.
 */
`timescale 1ns/1ps
module ccb_cpu_model (
    input  wire logic       clk,
    output logic            cpu_sync,
    output logic            cpu_dbin,
    output logic [7:0]      cpu_data_in
);
    // Idle: no cycle in progress
    initial begin
        cpu_sync    = 1'b0;
        cpu_dbin    = 1'b0;
        cpu_data_in = 8'hff;
    end

    // One fetch: status during sync, then a data-in strobe
    task automatic fetch(input logic [7:0] st);
        @(negedge clk);
        cpu_sync    = 1'b1;
        cpu_data_in = st;
        repeat (8) @(negedge clk);
        cpu_sync    = 1'b0;
        cpu_data_in = ~st; // Released lines do not keep the status
        cpu_dbin    = 1'b1;
        repeat (8) @(negedge clk);
        cpu_dbin    = 1'b0;
        repeat (4) @(negedge clk);
    endtask
endmodule

/* File: dv/ccb_support_tb_top.sv */
/*
 * Self-checking bench for the clock, reset and bus support block.
 * Assumes ccb_support and the processor model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("[FAIL] %0t %h %h", $time, a, b); end end
module ccb_support_tb_top;
    import ccb_pkg::*;
    logic clk, nrst, wide_phase, power_on_clear_n, prdy, xrdy, preset_n, phold_n, digi;
    logic cc_dsb_n, stat_dsb_n, do_dsb_n, add_dsb_n, keyboard_port_read, parallel_port_read;
    logic internal_port_sel, mem_sel, display_page_hit, cpu_dbin, cpu_sync, cpu_inte;
    logic cpu_hlda, cpu_wr_n, cpu_wait, phase1_n, phase2_n, bus_clock, cpu_reset, cpu_ready;
    logic cpu_hold, phantom_n, bus_sync, bus_inte, bus_hlda, bus_wr_n, bus_wait, bus_pdbin;
    logic ctl_oe, status_oe, addr_oe, dio_oe, cpu_data_oe, input_select_a, input_select_b;
    logic data_out_inhibit;
    logic [1:0] div_sel;
    logic [7:0] cpu_data_in, kdb, pid, intb, dio_in, status, dio_out, cpu_data_out;
    int mismatches = 0;
    int cmp_count = 0;

    ccb_support dut (.clk, .nrst, .div_sel, .wide_phase, .power_on_clear_n, .prdy, .xrdy,
        .preset_n, .phold_n, .digi, .cc_dsb_n, .stat_dsb_n, .do_dsb_n, .add_dsb_n,
        .keyboard_port_read, .parallel_port_read, .internal_port_sel, .mem_sel,
        .display_page_hit, .cpu_dbin, .cpu_sync, .cpu_inte, .cpu_hlda, .cpu_wr_n, .cpu_wait,
        .cpu_data_in, .kdb, .pid, .intb, .dio_in, .phase1_n, .phase2_n, .bus_clock,
        .cpu_reset, .cpu_ready, .cpu_hold, .phantom_n, .bus_sync, .bus_inte, .bus_hlda,
        .bus_wr_n, .bus_wait, .bus_pdbin, .ctl_oe, .status, .status_oe, .addr_oe, .dio_out,
        .dio_oe, .cpu_data_out, .cpu_data_oe, .input_select_a, .input_select_b,
        .data_out_inhibit);
    ccb_cpu_model cpu (.clk, .cpu_sync, .cpu_dbin, .cpu_data_in);

    // Base clock, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task close_out;
        if (mismatches == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task tmo;
        mismatches++;
        close_out();
    endtask

    // Strap, clear, release; then phase widths, lag and overlap over four periods
    task automatic cfg(input logic [1:0] d, input logic w, input int p1, p2, p);
        int n, a, b, f;
        logic q;
        nrst = 1'b0; div_sel = d; wide_phase = w; power_on_clear_n = 1'b0; phold_n = 1'b0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (14) @(negedge clk);
        `CHK(cpu_reset, 1'b1)
        `CHK(cpu_ready, 1'b0)
        `CHK(cpu_hold, 1'b1)
        phold_n = 1'b1; power_on_clear_n = 1'b1;
        n = 0;
        while (cpu_reset !== 1'b0) begin if (++n > 40) tmo(); @(negedge clk); end
        `CHK(cpu_ready, 1'b0)
        n = 0;
        while (cpu_ready !== 1'b1) begin if (++n > 40) tmo(); @(negedge clk); end
        `CHK(n, p)
        `CHK(cpu_hold, 1'b0)
        // Straps moved after clear must not change the rate
        div_sel = d ^ 2'h1; wide_phase = ~w;
        a = 0; b = 0; f = 0; q = phase2_n;
        for (n = 0; n < 4 * p; n++) begin
            @(negedge clk);
            a += (phase1_n === 1'b0);
            b += (phase2_n === 1'b0);
            f += (q === 1'b1 && phase2_n === 1'b0);
            `CHK(bus_clock, ~q)
            `CHK(phase1_n | phase2_n, 1'b1)
            q = phase2_n;
        end
        `CHK(a, 4 * p1)
        `CHK(b, 4 * p2)
        `CHK(f, 4)
    endtask

    // Ready lines combine; bus reset request reaches the processor
    task rdy;
        xrdy = 1'b0; repeat (20) @(negedge clk);
        `CHK(cpu_ready, 1'b0)
        xrdy = 1'b1; prdy = 1'b0; repeat (20) @(negedge clk);
        `CHK(cpu_ready, 1'b0)
        prdy = 1'b1; preset_n = 1'b0; repeat (20) @(negedge clk);
        `CHK(cpu_reset, 1'b1)
        preset_n = 1'b1; repeat (20) @(negedge clk);
        `CHK(cpu_reset, 1'b0)
        `CHK(cpu_ready, 1'b1)
    endtask

    // Four fetches after clear: start-up window and status latch
    task automatic phan;
        logic [7:0] s;
        for (int i = 0; i < PHANTOM_FETCHES; i++) begin
            `CHK(phantom_n, 1'b0)
            s = 8'h3c ^ 8'(i * 17);
            cpu.fetch(s);
            `CHK(status, s)
        end
        `CHK(phantom_n, 1'b1)
    endtask

    // Read source selection for each decode case
    task automatic mux;
        logic [4:0] c [6] = '{5'h00, 5'h10, 5'h08, 5'h04, 5'h02, 5'h03};
        logic [1:0] es [6] = '{2'h3, 2'h1, 2'h2, 2'h0, 2'h0, 2'h3};
        logic [7:0] e;
        for (int i = 0; i < 6; i++) begin
            kdb = 8'h10 + 8'(i); pid = 8'h20 + 8'(i); intb = 8'h40 + 8'(i);
            dio_in = 8'h80 + 8'(i);
            {keyboard_port_read, parallel_port_read, internal_port_sel, mem_sel,
             display_page_hit} = c[i];
            e = es[i] == 2'h3 ? dio_in : es[i] == 2'h1 ? kdb : es[i] == 2'h2 ? pid : intb;
            fork
                cpu.fetch(8'h00);
                begin
                    repeat (5) @(negedge clk);
                    `CHK(bus_sync, 1'b1)
                    repeat (8) @(negedge clk);
                    `CHK({input_select_a, input_select_b}, es[i])
                    `CHK(cpu_data_out, e)
                    `CHK(cpu_data_oe, 1'b1)
                    `CHK(data_out_inhibit, es[i] != 2'h3)
                    `CHK(dio_oe, es[i] == 2'h3)
                    `CHK(dio_out, 8'hff)
                    `CHK(bus_pdbin, 1'b1)
                end
            join
            `CHK(cpu_data_oe, 1'b0)
        end
    endtask

    // Driver disables from an outside master, read strobe override
    task dsb;
        {cc_dsb_n, stat_dsb_n, do_dsb_n, add_dsb_n} = 4'h0; digi = 1'b1; cpu_inte = 1'b1;
        cpu_hlda = 1'b1;
        cpu_wr_n = 1'b0;
        cpu_wait = 1'b1;
        repeat (4) @(negedge clk);
        `CHK(ctl_oe, 1'b0)
        `CHK(status_oe, 1'b0)
        `CHK(dio_oe, 1'b0)
        `CHK(addr_oe, 1'b0)
        `CHK(bus_pdbin, 1'b1)
        `CHK(bus_inte, 1'b1)
        `CHK({bus_hlda, bus_wr_n, bus_wait}, 3'h5)
        {cc_dsb_n, stat_dsb_n, do_dsb_n, add_dsb_n} = 4'hf; digi = 1'b0;
        cpu_hlda = 1'b0;
        cpu_wr_n = 1'b1;
        cpu_wait = 1'b0;
        repeat (4) @(negedge clk);
        `CHK({ctl_oe, status_oe, dio_oe, addr_oe, bus_pdbin}, 5'h1e)
        `CHK({bus_hlda, bus_wr_n, bus_wait}, 3'h2)
    endtask

    // Main sequence
    initial begin
        nrst = 1'b0; div_sel = 2'h0; wide_phase = 1'b1; power_on_clear_n = 1'b0;
        prdy = 1'b1; xrdy = 1'b1; preset_n = 1'b1; phold_n = 1'b1; digi = 1'b0;
        {cc_dsb_n, stat_dsb_n, do_dsb_n, add_dsb_n} = 4'hf;
        {keyboard_port_read, parallel_port_read, internal_port_sel} = 3'h0;
        mem_sel = 1'b0; display_page_hit = 1'b0;
        cpu_inte = 1'b0; cpu_hlda = 1'b0; cpu_wr_n = 1'b1; cpu_wait = 1'b0;
        kdb = 8'h00; pid = 8'h00; intb = 8'h00; dio_in = 8'h00;
        cfg(DIV_SEVEN, 1'b1, PH1_SLOW_CYC, PH2_SLOW_CYC, 7);
        phan();
        rdy();
        mux();
        dsb();
        cfg(DIV_SIX, 1'b0, PH1_FAST_CYC, PH2_FAST_CYC, 6);
        cfg(DIV_FIVE, 1'b1, PH1_FAST_CYC, PH2_FAST_CYC, 5);
        close_out();
    end
endmodule
